// ===== design/fault_sup_pkg.sv
package fault_sup_pkg;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS     = 8;
  localparam int GLITCH_FILTER_NS  = 50;
  // least time, rounded up to whole cycles
  localparam int GLITCH_CYCLES     = (GLITCH_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DEAD_CFG_W        = 4;
  localparam int DEAD_STEP_CYCLES  = 4;   // cycles per dead time step
  localparam int DEAD_MIN_CYCLES   = 2;   // fixed hardware minimum
  localparam int UV2_SEL_W         = 2;

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic enable_error;
    logic primary_reset;
    logic secondary_undervoltage_error;
    logic shoot_through_error;
    logic serial_command_error;
    logic collector_voltage_error;
    logic overcurrent_error;
  } error_flags_t;

  typedef struct packed {
    logic enable_valid;
    logic secondary_undervoltage_live;
    logic shoot_through;
  } live_status_t;

  localparam error_flags_t FLAGS_RESET = '0;

  // operating state of the output path
  typedef enum logic [1:0] {
    ST_ACTIVE  = 2'b00,
    ST_TURNOFF = 2'b01,
    ST_LOCKED  = 2'b10
  } op_state_t;

endpackage : fault_sup_pkg

// ===== design/gate_driver_fault_supervisor.sv
`timescale 1ns/1ns
module gate_driver_fault_supervisor
  import fault_sup_pkg::*;
#(
  parameter int DEAD_W = DEAD_CFG_W
) (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 clk_en,
  input  wire logic                 pwm_input,
  input  wire logic                 counterpart_pwm_input,
  input  wire logic                 enable_in,
  input  wire logic                 primary_uv_low,
  input  wire logic                 primary_uv_high,
  input  wire logic [UV2_SEL_W-1:0] secondary_uv_below,
  input  wire logic [UV2_SEL_W-1:0] secondary_uv_above,
  input  wire logic                 secondary_below_reset,
  input  wire logic [UV2_SEL_W-1:0] secondary_undervoltage_threshold_select,
  input  wire logic [DEAD_W-1:0]    dead_time_config,
  input  wire logic                 collector_voltage_monitor,
  input  wire logic                 overcurrent_monitor,
  input  wire logic                 cmd_valid,
  input  wire logic                 cmd_frame_bad,
  input  wire logic                 cmd_parity_bad,
  input  wire logic                 parity_check_disable,
  input  wire error_flags_t         flag_clear,
  input  wire logic                 reenable,
  output logic                      gate_on,
  output logic                      emergency_turnoff,
  output logic                      fault_a_output,
  output logic                      fault_b_output,
  output logic                      reset_ready_output,
  output error_flags_t              error_flags,
  output live_status_t              live_status
);

  // refused at elaboration: the dead time counter is sized for at most 8 config bits
  if (DEAD_W < 1 || DEAD_W > 8) begin : g_dead_w_check
    $error("DEAD_W out of range");
  end

  // ****************************************************************
  // pin synchronisers: three stages, change accepted when 2 and 3 agree
  // ****************************************************************
  localparam int NPIN = 7;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] s1_reg, s2_reg, s3_reg, pin_reg;
  assign pin_raw = {pwm_input, counterpart_pwm_input, enable_in, primary_uv_low,
                    primary_uv_high, collector_voltage_monitor, overcurrent_monitor};

  always_ff @(posedge clk) begin
    if (rst) begin
      s1_reg  <= '0;
      s2_reg  <= '0;
      s3_reg  <= '0;
      pin_reg <= '0;
    end else if (clk_en) begin
      s1_reg <= pin_raw;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      // stage 1 is never read here, only stages 2 and 3
      pin_reg <= (s2_reg & s3_reg) | (pin_reg & (s2_reg | s3_reg));
    end
  end

  logic pwm_s, cp_s, en_s, uv1_low_s, uv1_high_s, cv_s, oc_s;
  assign {pwm_s, cp_s, en_s, uv1_low_s, uv1_high_s, cv_s, oc_s} = pin_reg;

  // secondary comparators: same three-stage scheme
  logic [2*UV2_SEL_W:0] sec_raw, t1_reg, t2_reg, t3_reg, sec_reg;
  assign sec_raw = {secondary_below_reset, secondary_uv_below, secondary_uv_above};
  always_ff @(posedge clk) begin
    if (rst) begin
      t1_reg  <= '0;
      t2_reg  <= '0;
      t3_reg  <= '0;
      sec_reg <= '0;
    end else if (clk_en) begin
      t1_reg  <= sec_raw;
      t2_reg  <= t1_reg;
      t3_reg  <= t2_reg;
      sec_reg <= (t2_reg & t3_reg) | (sec_reg & (t2_reg | t3_reg));
    end
  end

  logic                 sec_rst_s;
  logic [UV2_SEL_W-1:0] uv2_below_s, uv2_above_s;
  assign {sec_rst_s, uv2_below_s, uv2_above_s} = sec_reg;

  // ****************************************************************
  // supply supervision
  // ****************************************************************
  logic uv1_reg, uv2_reg, en_prev_reg;
  logic uv2_fall, uv1_rise, en_fall;

  // threshold select picks which comparator pair is watched
  assign uv2_fall = uv2_below_s[secondary_undervoltage_threshold_select % UV2_SEL_W];
  assign uv1_rise = uv1_reg && uv1_high_s && !uv1_low_s;
  assign en_fall  = en_prev_reg && !en_s;

  // hysteresis: set below low threshold, clear only above high threshold
  always_ff @(posedge clk) begin
    if (rst) begin
      uv1_reg     <= 1'b0;
      uv2_reg     <= 1'b0;
      en_prev_reg <= 1'b0;
    end else if (clk_en) begin
      en_prev_reg <= en_s;
      if (uv1_low_s) begin
        uv1_reg <= 1'b1;
      end else if (uv1_rise) begin
        uv1_reg <= 1'b0;
      end
      if (sec_rst_s) begin
        uv2_reg <= 1'b1;
      end else if (uv2_fall) begin
        uv2_reg <= 1'b1;
      end else if (uv2_above_s[secondary_undervoltage_threshold_select % UV2_SEL_W]) begin
        uv2_reg <= 1'b0;
      end
    end
  end

  assign reset_ready_output = !uv1_reg;

  // ****************************************************************
  // shoot-through guard, always active, no disable
  // ****************************************************************
  localparam int DCNT_W = DEAD_W + 4;
  logic [DCNT_W-1:0] dead_cnt_reg;
  logic [3:0]        overlap_cnt_reg;
  logic              inhibit;

  function automatic logic [DCNT_W-1:0] dead_load(input logic [DEAD_W-1:0] cfg);
    dead_load = DCNT_W'(DEAD_MIN_CYCLES) + DCNT_W'(cfg) * DCNT_W'(DEAD_STEP_CYCLES);
  endfunction : dead_load

  // counter reloads while counterpart on, runs down after it turns off
  always_ff @(posedge clk) begin
    if (rst) begin
      dead_cnt_reg <= '0;
    end else if (clk_en) begin
      if (cp_s) begin
        dead_cnt_reg <= dead_load(dead_time_config);
      end else if (dead_cnt_reg != '0) begin
        dead_cnt_reg <= dead_cnt_reg - 1'b1;
      end
    end
  end

  assign inhibit = cp_s || (dead_cnt_reg != '0);

  // overlap must last the filter time before it counts
  always_ff @(posedge clk) begin
    if (rst) begin
      overlap_cnt_reg <= '0;
    end else if (clk_en) begin
      if (!(inhibit && pwm_s)) begin
        overlap_cnt_reg <= '0;
      end else if (overlap_cnt_reg < 4'(GLITCH_CYCLES)) begin
        overlap_cnt_reg <= overlap_cnt_reg + 1'b1;
      end
    end
  end

  logic stp_event;
  assign stp_event = (overlap_cnt_reg == 4'(GLITCH_CYCLES - 1)) && inhibit && pwm_s;

  // ****************************************************************
  // operating state
  // ****************************************************************
  op_state_t state_reg;
  logic      fault_any;
  assign fault_any = uv1_reg || uv2_reg || !en_s || en_fall
                     || cv_s || oc_s;

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= ST_LOCKED;
    end else if (clk_en) begin
      unique case (state_reg)
        ST_ACTIVE: begin
          if (fault_any) state_reg <= ST_TURNOFF;
        end
        ST_TURNOFF: begin
          state_reg <= ST_LOCKED;
        end
        ST_LOCKED: begin
          // re-enable only once supplies recovered and enable valid
          if (reenable && !fault_any) state_reg <= ST_ACTIVE;
        end
        default: state_reg <= ST_LOCKED;
      endcase
    end
  end

  assign emergency_turnoff = (state_reg == ST_TURNOFF);

  // gate follows pwm only while active and not inhibited
  always_ff @(posedge clk) begin
    if (rst) begin
      gate_on <= 1'b0;
    end else if (clk_en) begin
      gate_on <= (state_reg == ST_ACTIVE) && !fault_any && pwm_s && !inhibit;
    end
  end

  // fault notifications asserted on the state change, held low-active
  always_ff @(posedge clk) begin
    if (rst) begin
      fault_a_output <= 1'b1;
      fault_b_output <= 1'b1;
    end else if (clk_en) begin
      if (state_reg == ST_ACTIVE && fault_any && (en_fall || !en_s || cv_s || oc_s)) begin
        fault_a_output <= 1'b0;
      end else if (reenable && state_reg == ST_LOCKED) begin
        fault_a_output <= 1'b1;
      end
      if (state_reg == ST_ACTIVE && uv2_reg) begin
        fault_b_output <= 1'b0;
      end else if (reenable && state_reg == ST_LOCKED) begin
        fault_b_output <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // latched error flags: set wins over clear
  // ****************************************************************
  logic         cmd_err;
  error_flags_t set_vec;
  assign cmd_err = cmd_valid && (cmd_frame_bad || (cmd_parity_bad && !parity_check_disable));

  always_comb begin
    set_vec                              = '0;
    set_vec.enable_error                 = en_fall;
    set_vec.primary_reset                = uv1_rise;
    set_vec.secondary_undervoltage_error = uv2_fall && !uv2_reg;
    set_vec.shoot_through_error          = stp_event;
    set_vec.serial_command_error         = cmd_err;
    set_vec.collector_voltage_error      = cv_s && state_reg == ST_ACTIVE;
    set_vec.overcurrent_error            = oc_s && state_reg == ST_ACTIVE;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      error_flags <= FLAGS_RESET;
    end else if (clk_en) begin
      error_flags <= set_vec | (error_flags & ~flag_clear);
    end
  end

  // live status, independent of latched flags
  always_ff @(posedge clk) begin
    if (rst) begin
      live_status <= '0;
    end else if (clk_en) begin
      live_status.enable_valid                <= en_s;
      live_status.secondary_undervoltage_live <= uv2_reg;
      live_status.shoot_through               <= inhibit;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  chk_gate_inhibit: assert property (@(posedge clk) disable iff (rst)
    clk_en && cp_s |=> !gate_on) else $error("gate on while counterpart on");

  chk_flag_hold: assert property (@(posedge clk) disable iff (rst)
    clk_en && error_flags.enable_error && !flag_clear.enable_error |=> error_flags.enable_error)
    else $error("enable flag dropped");

  chk_reset_ready: assert property (@(posedge clk) disable iff (rst)
    clk_en && uv1_low_s |=> !reset_ready_output) else $error("reset ready high in undervoltage");

  chk_cmd_error: assert property (@(posedge clk) disable iff (rst)
    clk_en && cmd_valid && cmd_frame_bad |=> error_flags.serial_command_error)
    else $error("serial error not flagged");

  chk_enable_fall: assert property (@(posedge clk) disable iff (rst)
    clk_en && en_fall |=> error_flags.enable_error) else $error("enable flag not set");

  chk_stp_flag: assert property (@(posedge clk) disable iff (rst)
    clk_en && stp_event |=> error_flags.shoot_through_error) else $error("stp flag not set");

  chk_short_glitch: assert property (@(posedge clk) disable iff (rst)
    clk_en && stp_event |-> $past(inhibit && pwm_s, 6)) else $error("stp set on glitch");

  chk_uv2_turnoff: assert property (@(posedge clk) disable iff (rst)
    clk_en && state_reg == ST_ACTIVE && uv2_reg |=> state_reg == ST_TURNOFF)
    else $error("no turn-off on secondary undervoltage");

endmodule : gate_driver_fault_supervisor

// ===== sim/host_model.sv
`timescale 1ns/1ns
module host_model #(
  parameter int HOST_GAP = 64
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic local_req,
  input  wire logic other_req,
  input  wire logic raw,
  output logic      pwm_input,
  output logic      counterpart_pwm_input
);
  // ****************************************************************
  // host pwm with its own dead time
  // ****************************************************************
  logic [7:0] gap_reg;

  // quiet cycles of the counterpart, longer than the largest guard dead time
  always_ff @(posedge clk) begin
    if (rst || other_req) begin
      gap_reg <= 8'h00;
    end else if (gap_reg != 8'(HOST_GAP)) begin
      gap_reg <= gap_reg + 8'h01;
    end
  end

  // raw mode passes conflicting commands on purpose, to exercise the guard
  always_comb begin
    counterpart_pwm_input = other_req;
    pwm_input = raw ? local_req : (local_req && !other_req && gap_reg == 8'(HOST_GAP));
  end
endmodule : host_model

// ===== sim/gate_driver_fault_supervisor_test.sv
`timescale 1ns/1ns
module gate_driver_fault_supervisor_test;
  import fault_sup_pkg::*;
  // ****************************************************************
  // bench signals and instances
  // ****************************************************************
  logic clk = 0, rst = 1, enable_in = 1, p_low = 0, p_high = 1, below_rst = 0;
  logic local_req = 0, other_req = 0, raw = 0, pwm, cpwm, reenable = 0;
  logic [UV2_SEL_W-1:0] uv_below = '0, uv_above = '1, uv_sel = '0;
  logic [DEAD_CFG_W-1:0] dead_cfg = '0;
  logic col_mon = 0, oc_mon = 0, cmd_valid = 0, frame_bad = 0, par_bad = 0, par_dis = 0;
  error_flags_t flag_clear = '0, error_flags;
  live_status_t live_status;
  logic gate_on, fault_a, fault_b, ready;
  logic eto, clk_en = 1;
  int eto_seen = 0;
  localparam int BLANK_CYCLES = 8; // host blanking, plateau time already folded in
  int err_total = 0, samples_checked = 0, n;

  always #4 clk = ~clk;

  // turn-off is a one-cycle output: count it mid-cycle, where it has settled
  always @(negedge clk) begin
    if (eto === 1'b1) eto_seen++;
  end

  host_model u_host_model (.clk(clk), .rst(rst), .local_req(local_req), .other_req(other_req), .raw(raw),
    .pwm_input(pwm), .counterpart_pwm_input(cpwm));

  gate_driver_fault_supervisor u_gate_driver_fault_supervisor (.clk(clk), .rst(rst), .clk_en(clk_en),
    .pwm_input(pwm), .counterpart_pwm_input(cpwm), .enable_in(enable_in), .primary_uv_low(p_low),
    .primary_uv_high(p_high), .secondary_uv_below(uv_below), .secondary_uv_above(uv_above),
    .secondary_below_reset(below_rst), .secondary_undervoltage_threshold_select(uv_sel),
    .dead_time_config(dead_cfg), .collector_voltage_monitor(col_mon), .overcurrent_monitor(oc_mon),
    .cmd_valid(cmd_valid), .cmd_frame_bad(frame_bad), .cmd_parity_bad(par_bad),
    .parity_check_disable(par_dis), .flag_clear(flag_clear), .reenable(reenable), .gate_on(gate_on),
    .emergency_turnoff(eto), .fault_a_output(fault_a), .fault_b_output(fault_b),
    .reset_ready_output(ready), .error_flags(error_flags), .live_status(live_status));

  // ****************************************************************
  // helpers
  // ****************************************************************
  // inputs move 1 ns after the edge, never on it
  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : step

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic clr();
    flag_clear = '1;
    step(2);
    flag_clear = '0;
    step(1);
  endtask : clr

  // inputs need the sync delay before the pulse counts
  task automatic rearm();
    step(8);
    reenable = 1;
    step(1);
    reenable = 0;
    step(8);
  endtask : rearm

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : give_verdict

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    step(8);
    rst = 0;
    check({error_flags, fault_a, gate_on}, 8'h02);
    check({fault_b, ready}, 8'h03);
    $display("test reset done");
    local_req = 1;
    rearm();
    step(64);
    check(gate_on, 1);
    enable_in = 0;
    step(8);
    check({gate_on, fault_a, error_flags.enable_error}, 8'h01);
    check(live_status.enable_valid, 0);
    check(eto_seen, 1);
    enable_in = 1;
    step(8);
    check({live_status.enable_valid, error_flags.enable_error, fault_a}, 8'h06);
    clr();
    check(error_flags, 8'h00);
    rearm();
    check({fault_a, gate_on}, 8'h03);
    $display("test enable done");
    {p_low, p_high} = 2'b10;
    step(8);
    check({ready, gate_on}, 8'h00);
    check(eto_seen, 2);
    {p_low, p_high} = 2'b01;
    step(8);
    check({ready, error_flags.primary_reset}, 8'h03);
    clr();
    $display("test primary supply done");
    for (int s = 0; s < 2; s++) begin
      uv_sel = UV2_SEL_W'(s);
      rearm();
      uv_below[1-s] = 1;
      step(8);
      check(error_flags.secondary_undervoltage_error, 0);
      uv_below[s] = 1;
      uv_above[s] = 0;
      step(8);
      check({error_flags.secondary_undervoltage_error, fault_b, gate_on}, 8'h04);
      check(live_status.secondary_undervoltage_live, 1);
      uv_below = '0;
      uv_above = '1;
      step(8);
      check(live_status.secondary_undervoltage_live, 0);
      clr();
      rearm();
      check({fault_b, gate_on}, 8'h03);
    end
    $display("test secondary supply done");
    below_rst = 1;
    step(8);
    check(gate_on, 0);
    below_rst = 0;
    clr();
    rearm();
    for (int m = 1; m < 4; m++) begin
      step(BLANK_CYCLES);
      {col_mon, oc_mon} = 2'(m);
      step(8);
      check({error_flags.collector_voltage_error, error_flags.overcurrent_error}, 8'(m));
      check({fault_a, gate_on}, 8'h00);
      {col_mon, oc_mon} = 2'b00;
      clr();
      rearm();
    end
    $display("test monitors done");
    raw = 1;
    other_req = 1;
    step(3);
    other_req = 0;
    step(20);
    check(error_flags.shoot_through_error, 0);
    for (int c = 0; c < 4; c += 3) begin
      dead_cfg = DEAD_CFG_W'(c);
      other_req = 1;
      step(12);
      check({gate_on, error_flags.shoot_through_error, live_status.shoot_through}, 8'h03);
      other_req = 0;
      for (n = 0; n < 100 && gate_on !== 1'b1; n++) step(1);
      check(n >= DEAD_MIN_CYCLES + DEAD_STEP_CYCLES * c, 1);
      check(n <= DEAD_MIN_CYCLES + DEAD_STEP_CYCLES * c + 10, 1);
      clr();
    end
    raw = 0;
    $display("test shoot-through done");
    for (int k = 0; k < 5; k++) begin
      {frame_bad, par_bad, par_dis} = 3'(6'b100_010 >> (3 * (k % 2))) | ((k > 1) ? 3'b001 : 3'b000);
      cmd_valid = 1;
      step(1);
      cmd_valid = 0;
      step(2);
      check(error_flags.serial_command_error, (frame_bad || (par_bad && !par_dis)) ? 8'h01 : 8'h00);
      clr();
    end
    frame_bad = 1;
    cmd_valid = 1;
    step(1);
    cmd_valid = 0;
    step(2);
    check(error_flags.serial_command_error, 1);
    // a command seen while the clock enable is low must leave no trace
    clr();
    clk_en = 0;
    cmd_valid = 1;
    step(1);
    cmd_valid = 0;
    step(2);
    clk_en = 1;
    step(2);
    check(error_flags.serial_command_error, 0);
    $display("test serial command done");
    give_verdict();
  end

  // cut a hang short
  initial begin
    #200000;
    err_total++;
    give_verdict();
  end
endmodule : gate_driver_fault_supervisor_test
